// [ipf_formatter.sv]
`timescale 1ns/1ps
`default_nettype none
module ipf_formatter import ipf_pkg::*; (
   input  wire logic            clk_i,
   input  wire logic            rst_b_i,
   input  wire logic [3:0]      avs_address_i,
   input  wire logic            avs_read_i,
   input  wire logic            avs_write_i,
   input  wire logic [31:0]     avs_writedata_i,
   input  wire logic [3:0]      avs_byteenable_i,
   output logic      [31:0]     avs_readdata_o,
   output logic                 avs_waitrequest_o,
   input  wire logic            irq_i,
   input  wire ipf_type_t       irq_type_i,
   input  wire logic [CW-1:0]   irq_cause_i,
   input  wire logic            scan_op_i,
   input  wire logic            env_incon_i,
   input  wire logic [AW-1:0]   mem_addr_i,
   input  wire logic [3:0]      strobe_i,
   input  wire logic [7:0]      seq_cnt_i,
   input  wire logic [7:0]      uaddr_i,
   input  wire logic            uaddr_mode_i,
   input  wire logic [7:0]      opcode_i,
   input  wire logic [5:0]      fail_num_i,
   input  wire logic [WW-1:0]   tos_i,
   input  wire logic [AW-1:0]   sreg_i,
   input  wire logic [WW-1:0]   fault_word_i,
   input  wire logic [WW-1:0]   a_reg_i,
   input  wire logic [WW-1:0]   b_reg_i,
   input  wire logic            a_bad_i,
   input  wire logic            b_bad_i,
   input  wire logic            split_op_i,
   input  wire logic            join_op_i,
   input  wire logic            fam_c_i,
   input  wire logic            proc_entry_i,
   input  wire logic [AW-1:0]   proc_base_i,
   input  wire logic [6:0]      env_flags_i,
   input  wire logic [2:0]      psr_i,
   input  wire logic [12:0]     pir_i,
   input  wire logic [4:0]      ll_i,
   input  wire logic [13:0]     sdi_i,
   output logic                 stk_we_o,
   output logic      [AW-1:0]   stk_addr_o,
   output logic      [WW-1:0]   stk_data_o,
   output logic      [2:0]      stk_tag_o,
   output logic                 os_entry_o,
   output logic                 busy_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   ipf_state_t      state_r;
   ipf_state_t      state_nxt;
   logic [WW-1:0]   p1_w;
   logic [WW-1:0]   p3_w;
   logic [WW-1:0]   p2_nxt;
   logic [WW-1:0]   rcw_nxt;
   logic [WW-1:0]   cap_p1_r;
   logic [WW-1:0]   cap_p2_r;
   logic [WW-1:0]   cap_p3_r;
   ipf_type_t       cap_type_r;
   logic [AW-1:0]   frame_base_r;
   logic [WW-1:0]   rcw_r;
   logic [AW-1:0]   rcw_addr_r;
   logic            pend_r;
   logic [31:0]     ctrl_r;
   logic [31:0]     base_r;
   logic [15:0]     entries_r;
   logic [31:0]     rd_nxt;
   logic            accept_w;
   logic            req_w;
   logic            take_w;

   function automatic logic [31:0] be_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i])
            res[i*8 +: 8] = wd[i*8 +: 8];
      end
      return res;
   endfunction : be_merge

   ipf_cause_enc u_cause (
      .type_i  (irq_type_i),
      .cause_i (irq_cause_i),
      .scan_i  (scan_op_i),
      .incon_i (env_incon_i),
      .p1_o    (p1_w)
   );

   ipf_env_fmt u_env (
      .type_i    (irq_type_i),
      .cause_i   (irq_cause_i),
      .addr_i    (mem_addr_i),
      .strobe_i  (strobe_i),
      .seq_cnt_i (seq_cnt_i),
      .uaddr_i   (uaddr_i),
      .mode_i    (uaddr_mode_i),
      .opcode_i  (opcode_i),
      .num_i     (fail_num_i),
      .p3_o      (p3_w)
   );

   // context word source
   always_comb begin
      p2_nxt = tos_i;
      case (irq_type_i)
         IT_ALARM: begin
            if (irq_cause_i == C_STK_UNDER)
               p2_nxt = {{(WW-AW){1'b0}}, sreg_i};
         end
         IT_SDI: begin
            if (irq_cause_i == C_SEQ_ERR && fam_c_i)
               p2_nxt = fault_word_i;
            else if (irq_cause_i == C_INV_OP && split_op_i)
               p2_nxt = fault_word_i;
            else if (irq_cause_i == C_INV_OP && join_op_i)
               p2_nxt = (a_bad_i || !b_bad_i) ? a_reg_i : b_reg_i;
         end
         IT_EXT:  p2_nxt = '0;
         default: p2_nxt = tos_i;
      endcase
   end

   // return control word image
   always_comb begin
      rcw_nxt = '0;
      rcw_nxt[R_ES]         = env_flags_i[6];
      rcw_nxt[R_OF]         = env_flags_i[5];
      rcw_nxt[R_TF]         = env_flags_i[4];
      rcw_nxt[R_FL]         = env_flags_i[3];
      rcw_nxt[R_TFO]        = env_flags_i[2];
      rcw_nxt[R_CMP]        = env_flags_i[1];
      rcw_nxt[R_NCS]        = env_flags_i[0];
      rcw_nxt[R_PSR +: 3]   = psr_i;
      rcw_nxt[R_PIR +: 13]  = pir_i;
      rcw_nxt[R_LL +: 5]    = ll_i;
      rcw_nxt[R_SDI +: 14]  = sdi_i;
   end

   assign accept_w = irq_i && ctrl_r[0] && (state_r == S_IDLE);

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         S_IDLE: begin
            if (accept_w)
               state_nxt = S_P1;
            else if (pend_r)
               state_nxt = S_RCW;
         end
         S_P1:    state_nxt = S_P3;
         S_P3:    state_nxt = S_P2;
         S_P2:    state_nxt = S_ENT;
         S_ENT:   state_nxt = S_IDLE;
         S_RCW:   state_nxt = S_IDLE;
         default: state_nxt = S_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i)
         state_r <= S_IDLE;
      else
         state_r <= state_nxt;
   end

   // freeze context at detection
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         cap_p1_r     <= '0;
         cap_p2_r     <= '0;
         cap_p3_r     <= '0;
         cap_type_r   <= IT_ALARM;
         frame_base_r <= '0;
      end else if (accept_w) begin
         cap_p1_r     <= p1_w;
         cap_p2_r     <= p2_nxt;
         cap_p3_r     <= p3_w;
         cap_type_r   <= irq_type_i;
         frame_base_r <= base_r[AW-1:0];
      end
   end

   // procedure entry, set wins over clear
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         pend_r     <= 1'b0;
         rcw_r      <= '0;
         rcw_addr_r <= '0;
      end else begin
         if (proc_entry_i && (!pend_r || state_r == S_RCW)) begin
            rcw_r      <= rcw_nxt;
            rcw_addr_r <= proc_base_i + IDX_RCW;
         end
         if (proc_entry_i)
            pend_r <= 1'b1;
         else if (state_r == S_RCW)
            pend_r <= 1'b0;
      end
   end

   // stack write port
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         stk_we_o   <= 1'b0;
         stk_addr_o <= '0;
         stk_data_o <= '0;
         stk_tag_o  <= TAG_SP;
      end else begin
         stk_we_o <= 1'b1;
         case (state_r)
            S_P1: begin
               stk_addr_o <= frame_base_r + IDX_P1;
               stk_data_o <= cap_p1_r;
               stk_tag_o  <= TAG_DP;
            end
            S_P3: begin
               stk_addr_o <= frame_base_r + IDX_P3;
               stk_data_o <= cap_p3_r;
               stk_tag_o  <= TAG_DP;
            end
            S_P2: begin
               stk_addr_o <= frame_base_r + IDX_P2;
               stk_data_o <= cap_p2_r;
               stk_tag_o  <= TAG_SP;
            end
            S_RCW: begin
               stk_addr_o <= rcw_addr_r;
               stk_data_o <= rcw_r;
               stk_tag_o  <= TAG_RCW;
            end
            default: stk_we_o <= 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         os_entry_o <= 1'b0;
         busy_o     <= 1'b0;
         entries_r  <= '0;
      end else begin
         os_entry_o <= (state_r == S_ENT);
         busy_o     <= (state_nxt != S_IDLE);
         if (state_r == S_ENT)
            entries_r <= entries_r + 16'h0001;
      end
   end

   // avalon slave, one wait cycle per access
   assign req_w  = avs_read_i || avs_write_i;
   assign take_w = req_w && !avs_waitrequest_o;

   always_ff @(posedge clk_i) begin
      if (!rst_b_i)
         avs_waitrequest_o <= 1'b1;
      else
         avs_waitrequest_o <= !(req_w && avs_waitrequest_o);
   end

   always_comb begin
      case (avs_address_i)
         OFS_CTRL:  rd_nxt = ctrl_r;
         OFS_BASE:  rd_nxt = base_r;
         OFS_STAT:  rd_nxt = {entries_r, 14'h0000, pend_r,
                             state_r != S_IDLE};
         OFS_CAUSE: rd_nxt = cap_p1_r[31:0];
         default:   rd_nxt = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i)
         avs_readdata_o <= 32'h0000_0000;
      else if (avs_read_i && avs_waitrequest_o)
         avs_readdata_o <= rd_nxt;
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         ctrl_r <= CTRL_RST;
         base_r <= 32'h0000_0000;
      end else if (take_w && avs_write_i) begin
         if (avs_address_i == OFS_CTRL)
            ctrl_r <= be_merge(ctrl_r, avs_writedata_i,
                               avs_byteenable_i) & 32'h0000_0001;
         if (avs_address_i == OFS_BASE)
            base_r <= be_merge(base_r, avs_writedata_i,
                               avs_byteenable_i) & 32'h000f_ffff;
      end
   end

   AST_ENTRY_LAST: assert property (
      os_entry_o |-> $past(stk_we_o) &&
         $past(stk_addr_o) == frame_base_r + IDX_P2)
      else $error("handler entry before stack filled");

   AST_DP_PAIR: assert property (
      state_r == S_P1 |=> stk_data_o == cap_p1_r ##1
         stk_data_o == cap_p3_r && stk_tag_o == TAG_DP)
      else $error("cause and environment halves misplaced");

   AST_TOS_CTX: assert property (
      accept_w && irq_type_i == IT_HW |=> cap_p2_r == $past(tos_i))
      else $error("context word not top of stack");

   AST_UNDERFLOW: assert property (
      accept_w && irq_type_i == IT_ALARM &&
         irq_cause_i == C_STK_UNDER
      |=> cap_p2_r[AW-1:0] == $past(sreg_i))
      else $error("underflow context not stack pointer");

   AST_JOIN_A: assert property (
      accept_w && irq_type_i == IT_SDI && irq_cause_i == C_INV_OP &&
         !split_op_i && join_op_i && a_bad_i
      |=> cap_p2_r == $past(a_reg_i))
      else $error("join fault did not report A word");

   AST_EXT_EMPTY: assert property (
      state_r == S_P3 && cap_type_r == IT_EXT
      |=> stk_data_o == '0 ##1 stk_data_o == '0)
      else $error("external interrupt words not empty");

   AST_SYS_BIT: assert property (
      accept_w && (irq_type_i == IT_ALARM || irq_type_i == IT_GC)
      |=> cap_p1_r[P1_SYS])
      else $error("system bit of cause word low");

   AST_RCW_TAG: assert property (
      stk_we_o && stk_tag_o == TAG_RCW
      |-> $past(state_r == S_RCW) && stk_data_o == $past(rcw_r))
      else $error("return word written outside its step");

   AST_FREEZE: assert property (
      state_r != S_IDLE && $past(state_r) != S_IDLE
      |-> $stable(cap_p2_r) && $stable(cap_p3_r))
      else $error("captured context changed mid frame");

   AST_WAIT_ONE: assert property (
      req_w && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("bus answer later than one cycle");

   COV_IRQ: cover property (accept_w ##5 os_entry_o);
   COV_RCW: cover property (proc_entry_i ##[1:8] stk_tag_o == TAG_RCW);
   COV_EXT: cover property (accept_w && irq_type_i == IT_EXT);
   COV_BUS: cover property (take_w && avs_write_i);
endmodule : ipf_formatter
`default_nettype wire

// [ipf_pkg.sv]
package ipf_pkg;
   localparam int WW = 48;
   localparam int AW = 20;
   localparam int CW = 5;
   localparam logic [3:0]  OFS_CTRL  = 4'h0;
   localparam logic [3:0]  OFS_BASE  = 4'h4;
   localparam logic [3:0]  OFS_STAT  = 4'h8;
   localparam logic [3:0]  OFS_CAUSE = 4'hc;
   localparam logic [31:0] CTRL_RST  = 32'h0000_0001;
   localparam logic [2:0]  TAG_SP    = 3'h0;
   localparam logic [2:0]  TAG_DP    = 3'h2;
   localparam logic [2:0]  TAG_RCW   = 3'h3;
   localparam logic [AW-1:0] IDX_RCW = 20'h00001;
   localparam logic [AW-1:0] IDX_P1  = 20'h00002;
   localparam logic [AW-1:0] IDX_P3  = 20'h00003;
   localparam logic [AW-1:0] IDX_P2  = 20'h00004;
   typedef enum logic [2:0] {
      IT_ALARM = 3'h0, IT_HW = 3'h1, IT_GC = 3'h2,
      IT_EXT = 3'h3, IT_SDI = 3'h4
   } ipf_type_t;
   typedef enum logic [5:0] {
      S_IDLE = 6'h01, S_P1 = 6'h02, S_P3 = 6'h04,
      S_P2 = 6'h08, S_ENT = 6'h10, S_RCW = 6'h20
   } ipf_state_t;
   localparam logic [CW-1:0] C_LOOP      = 5'h01;
   localparam logic [CW-1:0] C_STK_UNDER = 5'h04;
   localparam logic [CW-1:0] C_INV_PW    = 5'h05;
   localparam logic [CW-1:0] C_PROM      = 5'h01;
   localparam logic [CW-1:0] C_RAM       = 5'h02;
   localparam logic [CW-1:0] C_RD_SINGLE = 5'h01;
   localparam logic [CW-1:0] C_RD_CHECK  = 5'h03;
   localparam logic [CW-1:0] C_INV_OP    = 5'h03;
   localparam logic [CW-1:0] C_SEQ_ERR   = 5'h0b;
   localparam int P1_CAUSE = 8;
   localparam int P1_SYS   = 27;
   localparam int P1_SCAN  = 18;
   localparam int P1_INCON = 17;
   localparam int P1_T_ALM = 26;
   localparam int P1_T_HW  = 25;
   localparam int P1_T_GC  = 21;
   localparam int P1_T_EXT = 20;
   localparam int P1_T_SDI = 39;
   localparam int P3_ADDR  = 28;
   localparam int P3_STRB  = 24;
   localparam int P3_CNT   = 16;
   localparam int P3_OP    = 8;
   localparam int P3_MODE  = 6;
   localparam int P3_NUM   = 0;
   localparam int R_ES  = 47;
   localparam int R_OF  = 46;
   localparam int R_TF  = 45;
   localparam int R_FL  = 44;
   localparam int R_TFO = 42;
   localparam int R_CMP = 41;
   localparam int R_PSR = 33;
   localparam int R_PIR = 20;
   localparam int R_NCS = 19;
   localparam int R_LL  = 14;
   localparam int R_SDI = 0;
endpackage : ipf_pkg

// [ipf_cause_enc.sv]
`timescale 1ns/1ps
`default_nettype none
module ipf_cause_enc import ipf_pkg::*; (
   input  wire ipf_type_t       type_i,
   input  wire logic [CW-1:0]   cause_i,
   input  wire logic            scan_i,
   input  wire logic            incon_i,
   output logic      [WW-1:0]   p1_o
);
   always_comb begin
      p1_o = '0;
      p1_o[P1_CAUSE +: CW] = cause_i;
      case (type_i)
         IT_ALARM: p1_o[P1_T_ALM] = 1'b1;
         IT_HW:    p1_o[P1_T_HW]  = 1'b1;
         IT_GC:    p1_o[P1_T_GC]  = 1'b1;
         IT_EXT:   p1_o[P1_T_EXT] = 1'b1;
         IT_SDI:   p1_o[P1_T_SDI] = 1'b1;
         default:  p1_o = '0;
      endcase
      if (type_i == IT_ALARM || type_i == IT_HW || type_i == IT_GC) begin
         p1_o[P1_SCAN]  = scan_i;
         p1_o[P1_INCON] = incon_i;
         p1_o[P1_SYS]   = 1'b1;
      end
   end
endmodule : ipf_cause_enc
`default_nettype wire

// [ipf_env_fmt.sv]
`timescale 1ns/1ps
`default_nettype none
module ipf_env_fmt import ipf_pkg::*; (
   input  wire ipf_type_t       type_i,
   input  wire logic [CW-1:0]   cause_i,
   input  wire logic [AW-1:0]   addr_i,
   input  wire logic [3:0]      strobe_i,
   input  wire logic [7:0]      seq_cnt_i,
   input  wire logic [7:0]      uaddr_i,
   input  wire logic            mode_i,
   input  wire logic [7:0]      opcode_i,
   input  wire logic [5:0]      num_i,
   output logic      [WW-1:0]   p3_o
);
   logic [WW-1:0] core_w;
   always_comb begin
      core_w = '0;
      core_w[P3_STRB +: 4] = strobe_i;
      core_w[P3_CNT +: 8]  = mode_i ? uaddr_i : seq_cnt_i;
      core_w[P3_MODE]      = mode_i;
      core_w[P3_OP +: 8]   = opcode_i;
   end
   always_comb begin
      p3_o = '0;
      case (type_i)
         IT_ALARM: begin
            p3_o = core_w;
            if (cause_i != C_LOOP && cause_i != C_INV_PW)
               p3_o[P3_ADDR +: AW] = addr_i;
         end
         IT_HW: begin
            p3_o = core_w;
            if (cause_i == C_PROM || cause_i == C_RAM)
               p3_o[P3_NUM +: 6] = num_i;
         end
         IT_GC: begin
            p3_o[P3_ADDR +: AW] = addr_i;
            if (cause_i == C_RD_SINGLE || cause_i == C_RD_CHECK)
               p3_o[P3_NUM +: 6] = num_i;
         end
         IT_SDI:  p3_o = core_w;
         IT_EXT:  p3_o = '0;
         default: p3_o = '0;
      endcase
   end
endmodule : ipf_env_fmt
`default_nettype wire

// [ipf_stack_mem.sv]
`timescale 1ns/1ps
`default_nettype none
module ipf_stack_mem import ipf_pkg::*; (
   input  wire logic            clk_i,
   input  wire logic            we_i,
   input  wire logic [AW-1:0]   addr_i,
   input  wire logic [WW-1:0]   data_i,
   input  wire logic [2:0]      tag_i
);
   logic [50:0] mem [0:1023];
   int          n_wr;

   initial begin
      n_wr = 0;
   end

   // stack memory: records every word with its tag
   always @(posedge clk_i) begin
      if (we_i === 1'b1) begin
         mem[addr_i[9:0]] <= {tag_i, data_i};
         n_wr <= n_wr + 1;
      end
   end
endmodule : ipf_stack_mem
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench import ipf_pkg::*;;
   logic            clk_i, rst_b_i, avs_read_i, avs_write_i;
   logic [3:0]      avs_address_i, avs_byteenable_i, strobe_i;
   logic [31:0]     avs_writedata_i, avs_readdata_o;
   logic            avs_waitrequest_o, irq_i, scan_op_i, env_incon_i;
   ipf_type_t       irq_type_i;
   logic [CW-1:0]   irq_cause_i;
   logic [AW-1:0]   mem_addr_i, sreg_i, proc_base_i, stk_addr_o;
   logic [7:0]      seq_cnt_i, uaddr_i, opcode_i;
   logic            uaddr_mode_i, a_bad_i, b_bad_i, split_op_i, join_op_i;
   logic [5:0]      fail_num_i;
   logic [WW-1:0]   tos_i, fault_word_i, a_reg_i, b_reg_i, stk_data_o;
   logic            fam_c_i, proc_entry_i, stk_we_o, os_entry_o, busy_o;
   logic [6:0]      env_flags_i;
   logic [2:0]      psr_i, stk_tag_o;
   logic [12:0]     pir_i;
   logic [4:0]      ll_i;
   logic [13:0]     seg_idx;
   logic [31:0]     q;
   int              n_mismatch, tests_run;

   ipf_formatter u_dut (.clk_i, .rst_b_i, .avs_address_i, .avs_read_i,
      .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
      .avs_waitrequest_o, .irq_i, .irq_type_i, .irq_cause_i, .scan_op_i,
      .env_incon_i, .mem_addr_i, .strobe_i, .seq_cnt_i, .uaddr_i,
      .uaddr_mode_i, .opcode_i, .fail_num_i, .tos_i, .sreg_i,
      .fault_word_i, .a_reg_i, .b_reg_i, .a_bad_i, .b_bad_i, .split_op_i,
      .join_op_i, .fam_c_i, .proc_entry_i, .proc_base_i, .env_flags_i,
      .psr_i, .pir_i, .ll_i, .sdi_i(seg_idx), .stk_we_o, .stk_addr_o,
      .stk_data_o, .stk_tag_o, .os_entry_o, .busy_o);

   ipf_stack_mem u_mem (.clk_i(clk_i), .we_i(stk_we_o),
      .addr_i(stk_addr_o), .data_i(stk_data_o), .tag_i(stk_tag_o));

   task automatic results;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : results

   task automatic chk_w(input logic [50:0] g, e, input string m);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask : chk_w

   task automatic chk_b(input logic g, e, input string m);
      chk_w({50'h0, g}, {50'h0, e}, m);
   endtask : chk_b

   task automatic chk_r(input logic [31:0] g, e, input string m);
      chk_w({19'h0, g}, {19'h0, e}, m);
   endtask : chk_r

   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [31:0] d, input logic [3:0] e);
      int n;
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_byteenable_i <= e;
      avs_read_i <= !w;
      avs_write_i <= w;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0);
      q = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
      chk_r(32'(n), 32'h2, "bus answer");
      @(posedge clk_i);
   endtask : bus

   task automatic rd_chk(input logic [3:0] a, input logic [31:0] e,
                         input string m);
      bus(1'b0, a, 32'h0, 4'hf);
      chk_r(q, e, m);
   endtask : rd_chk

   function automatic logic [WW-1:0] f_cause(ipf_type_t t, logic [4:0] c,
                                             logic s, logic i);
      logic [WW-1:0] w;
      w = '0;
      w[P1_CAUSE +: CW] = c;
      case (t)
         IT_ALARM: w[P1_T_ALM] = 1'b1;
         IT_HW:    w[P1_T_HW] = 1'b1;
         IT_GC:    w[P1_T_GC] = 1'b1;
         IT_EXT:   w[P1_T_EXT] = 1'b1;
         default:  w[P1_T_SDI] = 1'b1;
      endcase
      if (t inside {IT_ALARM, IT_HW, IT_GC}) begin
         w[P1_SYS] = 1'b1;
         w[P1_SCAN] = s;
         w[P1_INCON] = i;
      end
      return w;
   endfunction : f_cause

   function automatic logic [WW-1:0] f_env(ipf_type_t t, logic [4:0] c);
      logic [WW-1:0] w;
      w = '0;
      if (t == IT_EXT) return w;
      if (t == IT_GC) begin
         w[P3_ADDR +: AW] = mem_addr_i;
         if (c == C_RD_SINGLE || c == C_RD_CHECK) w[P3_NUM +: 6] = fail_num_i;
         return w;
      end
      w[P3_STRB +: 4] = strobe_i;
      w[P3_CNT +: 8] = uaddr_mode_i ? uaddr_i : seq_cnt_i;
      w[P3_MODE] = uaddr_mode_i;
      w[P3_OP +: 8] = opcode_i;
      if (t == IT_ALARM && c != C_LOOP && c != C_INV_PW)
         w[P3_ADDR +: AW] = mem_addr_i;
      if (t == IT_HW && (c == C_PROM || c == C_RAM))
         w[P3_NUM +: 6] = fail_num_i;
      return w;
   endfunction : f_env

   function automatic logic [WW-1:0] f_ctx(ipf_type_t t, logic [4:0] c);
      if (t == IT_EXT) return '0;
      if (t == IT_ALARM && c == C_STK_UNDER) return {28'h0, sreg_i};
      if (t == IT_SDI && c == C_SEQ_ERR && fam_c_i) return fault_word_i;
      if (t == IT_SDI && c == C_INV_OP && split_op_i) return fault_word_i;
      if (t == IT_SDI && c == C_INV_OP && join_op_i)
         return (a_bad_i || !b_bad_i) ? a_reg_i : b_reg_i;
      return tos_i;
   endfunction : f_ctx

   // inverts captured context except the fam_c_i, split/join and bad flags so late changes show up
   task automatic flip;
      {tos_i, fault_word_i, a_reg_i, b_reg_i} <=
         ~{tos_i, fault_word_i, a_reg_i, b_reg_i};
      {mem_addr_i, sreg_i, strobe_i, seq_cnt_i, uaddr_i, opcode_i} <=
         ~{mem_addr_i, sreg_i, strobe_i, seq_cnt_i, uaddr_i, opcode_i};
      {fail_num_i, scan_op_i, env_incon_i, uaddr_mode_i} <=
         ~{fail_num_i, scan_op_i, env_incon_i, uaddr_mode_i};
   endtask : flip

   task automatic frame(input ipf_type_t t, input logic [4:0] c,
                        input logic [7:0] f);
      logic [WW-1:0] ec, ee, ex;
      logic [9:0]    b;
      b = 10'h100;
      @(posedge clk_i);
      irq_i <= 1'b1;
      irq_type_i <= t;
      irq_cause_i <= c;
      {uaddr_mode_i, scan_op_i, env_incon_i, fam_c_i, split_op_i,
       join_op_i, a_bad_i, b_bad_i} <= f;
      #1;
      ec = f_cause(t, c, scan_op_i, env_incon_i);
      ee = f_env(t, c);
      ex = f_ctx(t, c);
      @(posedge clk_i);
      irq_i <= 1'b0;
      irq_type_i <= IT_EXT;
      irq_cause_i <= ~c;
      flip();
      for (int i = 1; i <= 5; i++) begin
         @(posedge clk_i);
         #1;
         chk_b(stk_we_o, i <= 3, "word write slot");
         chk_b(os_entry_o, i == 4, "handler entry slot");
         chk_b(busy_o, i <= 3, "busy while framing");
      end
      chk_w(u_mem.mem[b + 10'(IDX_P1)], {TAG_DP, ec}, "cause");
      chk_w(u_mem.mem[b + 10'(IDX_P3)], {TAG_DP, ee}, "env");
      chk_w(u_mem.mem[b + 10'(IDX_P2)], {TAG_SP, ex}, "ctx");
      @(posedge clk_i);
      flip();
   endtask : frame

   task automatic t_regs;
      rd_chk(OFS_CTRL, CTRL_RST, "ctrl reset");
      rd_chk(OFS_BASE, 32'h0, "base reset");
      bus(1'b1, OFS_BASE, 32'hffff_ffff, 4'hf);
      rd_chk(OFS_BASE, 32'h000f_ffff, "base width");
      bus(1'b1, OFS_BASE, 32'h0000_0100, 4'h3);
      rd_chk(OFS_BASE, 32'h000f_0100, "byte lanes");
      bus(1'b1, OFS_BASE, 32'h0000_0100, 4'hf);
      bus(1'b1, 4'h2, 32'hffff_ffff, 4'hf);
      rd_chk(4'h2, 32'h0, "unmapped read");
      rd_chk(OFS_CTRL, CTRL_RST, "unmapped write");
   endtask : t_regs

   task automatic t_frames;
      frame(IT_ALARM, C_STK_UNDER, 8'h40);
      rd_chk(OFS_CAUSE, 32'(f_cause(IT_ALARM, C_STK_UNDER, 1'b1, 1'b0)),
             "last cause");
      frame(IT_ALARM, C_LOOP, 8'h80);
      frame(IT_ALARM, C_INV_PW, 8'h00);
      frame(IT_HW, C_PROM, 8'h20);
      frame(IT_HW, 5'h03, 8'h00);
      frame(IT_GC, C_RD_SINGLE, 8'h00);
      frame(IT_GC, 5'h02, 8'h00);
      frame(IT_EXT, 5'h01, 8'h00);
      frame(IT_SDI, C_SEQ_ERR, 8'h10);
      frame(IT_SDI, C_INV_OP, 8'h08);
      frame(IT_SDI, C_INV_OP, 8'h07);
      frame(IT_SDI, C_INV_OP, 8'h05);
      rd_chk(OFS_STAT, 32'h000c_0000, "frame count");
   endtask : t_frames

   task automatic t_refuse;
      int n0;
      bus(1'b1, OFS_CTRL, 32'h0, 4'hf);
      n0 = u_mem.n_wr;
      irq_i <= 1'b1;
      @(posedge clk_i);
      irq_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      chk_r(32'(u_mem.n_wr - n0), 32'h0, "disabled irq");
      bus(1'b1, OFS_CTRL, 32'h1, 4'hf);
      n0 = u_mem.n_wr;
      irq_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      irq_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      chk_r(32'(u_mem.n_wr - n0), 32'h3, "irq while busy");
   endtask : t_refuse

   task automatic t_ret;
      logic [WW-1:0] ex;
      @(posedge clk_i);
      proc_entry_i <= 1'b1;
      proc_base_i <= 20'h00200;
      env_flags_i <= 7'h55;
      psr_i <= 3'h5;
      pir_i <= 13'h1a2b;
      ll_i <= 5'h13;
      seg_idx <= 14'h2c3d;
      @(posedge clk_i);
      proc_entry_i <= 1'b0;
      proc_base_i <= 20'h00000;
      ex = '0;
      {ex[R_ES], ex[R_OF], ex[R_TF], ex[R_FL]} = env_flags_i[6:3];
      {ex[R_TFO], ex[R_CMP], ex[R_NCS]} = env_flags_i[2:0];
      ex[R_PSR +: 3] = psr_i;
      ex[R_PIR +: 13] = pir_i;
      ex[R_LL +: 5] = ll_i;
      ex[R_SDI +: 14] = seg_idx;
      @(posedge clk_i);
      #1;
      chk_b(stk_we_o, 1'b0, "return word early");
      @(posedge clk_i);
      #1;
      chk_b(stk_we_o, 1'b1, "return word write");
      chk_r({12'h0, stk_addr_o}, 32'h0000_0201, "return slot");
      chk_w({stk_tag_o, stk_data_o}, {TAG_RCW, ex}, "return word");
   endtask : t_ret

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   initial begin
      #300us;
      n_mismatch++;
      results();
   end

   initial begin
      n_mismatch = 0;
      tests_run = 0;
      {rst_b_i, avs_read_i, avs_write_i, irq_i, proc_entry_i} = '0;
      {avs_address_i, avs_writedata_i, avs_byteenable_i} = '0;
      {irq_cause_i, scan_op_i, env_incon_i, uaddr_mode_i} = '0;
      irq_type_i = IT_ALARM;
      {fam_c_i, split_op_i, join_op_i, a_bad_i, b_bad_i} = '0;
      mem_addr_i = 20'h5a5a5;
      strobe_i = 4'h9;
      seq_cnt_i = 8'h3c;
      uaddr_i = 8'hc3;
      opcode_i = 8'h7e;
      fail_num_i = 6'h2d;
      tos_i = 48'h1234_5678_9abc;
      sreg_i = 20'h0abcd;
      fault_word_i = 48'hfeed_0bad_f00d;
      a_reg_i = 48'haaaa_0000_aaaa;
      b_reg_i = 48'h5555_1111_5555;
      {proc_base_i, env_flags_i, psr_i, pir_i, ll_i, seg_idx} = '0;
      repeat (12) @(posedge clk_i);
      rst_b_i <= 1'b1;
      @(posedge clk_i);
      t_regs();
      t_frames();
      t_refuse();
      t_ret();
      results();
   end
endmodule : testbench
`default_nettype wire
